/* include/mbsp_pkg.sv */
// Shared constants and types for the multibuffered serial port.
// Assumes one system clock; all counts are in system clock cycles.
package mbsp_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int WORD_W  = 16;
    localparam int IDX_W   = 8;
    localparam int ENTRIES = 256;
    localparam int SLOT_W  = 10;

    // ----------------------------------------------------------------
    // Entry field selects
    // ----------------------------------------------------------------
    localparam logic [1:0] FLD_TX   = 2'h0;
    localparam logic [1:0] FLD_RX   = 2'h1;
    localparam logic [1:0] FLD_CTRL = 2'h2;
    localparam logic [1:0] FLD_STAT = 2'h3;

    // ----------------------------------------------------------------
    // Per-word control field layout
    // ----------------------------------------------------------------
    localparam int CTL_LEN_LSB = 0;
    localparam int CTL_LEN_W   = 4;
    localparam int CTL_POL     = 4;
    localparam int CTL_PHA     = 5;
    localparam int CTL_HOLD    = 6;
    localparam int CTL_C2T_LSB = 8;
    localparam int CTL_T2C_LSB = 12;
    localparam int CTL_DLY_W   = 4;

    // ----------------------------------------------------------------
    // Status field layout and reset values
    // ----------------------------------------------------------------
    localparam int          ST_DONE  = 0;
    localparam int          ST_TGT   = 1;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam logic [15:0] RD_RST   = 16'h0000;

    // ----------------------------------------------------------------
    // Word length limits and select timing counts
    // ----------------------------------------------------------------
    localparam logic [4:0] LEN_MIN    = 5'h02;
    localparam logic [4:0] LEN_MAX    = 5'h10;
    localparam logic [8:0] SETUP_BASE = 9'h002;
    localparam logic [8:0] HOLD_EXTRA = 9'h001;
    localparam logic [8:0] HALF_BASE  = 9'h001;
    localparam logic [8:0] DESEL_BASE = 9'h001;
    localparam logic [8:0] DESEL_LAG  = 9'h002;

    // ----------------------------------------------------------------
    // Pin indices
    // ----------------------------------------------------------------
    localparam int PIN_SERIAL_CLOCK   = 0;
    localparam int PIN_CONTROLLER_OUT = 1;
    localparam int PIN_CONTROLLER_IN  = 2;
    localparam int PIN_SELECT         = 3;
    localparam int PIN_N              = 4;

    typedef enum logic [2:0] {
        S_IDLE, S_LOAD, S_SETUP, S_SHIFT, S_DESEL, S_NEXT
    } eng_state_e;

endpackage : mbsp_pkg

/* rtl/baud_gen.sv */
// Bit-rate divider: one-cycle tick every (divider + 1) clocks while running.
// Assumes the divider stays stable while running.
`timescale 1ns/1ps
module baud_gen
    import mbsp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Control
    input  wire logic       i_run,
    input  wire logic [7:0] i_div,
    // Half-period tick
    output logic            o_tick
);

    logic [7:0] cnt;

    assign o_tick = i_run && (cnt == i_div); // see R3

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 8'h00;
        end else if (!i_run || o_tick) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    tick_spacing_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // see R3
        (o_tick && i_div == 8'h03) ##1 (i_run && i_div == 8'h03)[*4] |-> o_tick)
        else $error("tick spacing wrong");

endmodule : baud_gen

/* rtl/entry_ram.sv */
// Buffer entries: 256 entries of four 16-bit fields held in flip-flops.
// Assumes the engine write wins over a host write to the same field.
`timescale 1ns/1ps
module entry_ram
    import mbsp_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    // Host port
    input  wire logic              i_host_we,
    input  wire logic [IDX_W-1:0]  i_host_entry,
    input  wire logic [1:0]        i_host_field,
    input  wire logic [WORD_W-1:0] i_host_wdata,
    output logic      [WORD_W-1:0] o_host_rdata,
    // Engine port
    input  wire logic [IDX_W-1:0]  i_eng_entry,
    input  wire logic              i_eng_we,
    input  wire logic [WORD_W-1:0] i_eng_rx,
    input  wire logic [WORD_W-1:0] i_eng_stat,
    output logic      [WORD_W-1:0] o_eng_tx,
    output logic      [WORD_W-1:0] o_eng_ctrl
);

    function automatic logic [SLOT_W-1:0] slot(input logic [IDX_W-1:0] e, input logic [1:0] f);
        slot = {e, f};
    endfunction : slot

    logic [WORD_W-1:0] mem [0:ENTRIES*4-1]; // see R7 see R8

    assign o_eng_tx   = mem[slot(i_eng_entry, FLD_TX)];
    assign o_eng_ctrl = mem[slot(i_eng_entry, FLD_CTRL)];

    // Engine write last so a completing word beats a host clear
    always_ff @(posedge i_clk_sys) begin
        if (i_host_we) begin
            mem[slot(i_host_entry, i_host_field)] <= i_host_wdata;
        end
        if (i_eng_we) begin
            mem[slot(i_eng_entry, FLD_RX)]   <= i_eng_rx;
            mem[slot(i_eng_entry, FLD_STAT)] <= i_eng_stat;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_host_rdata <= RD_RST;
        end else begin
            o_host_rdata <= mem[slot(i_host_entry, i_host_field)];
        end
    end

    host_readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // see R8
        (i_host_we && !i_eng_we) ##1 (!i_host_we && $stable(i_host_entry) && $stable(i_host_field))
        |=> o_host_rdata == $past(i_host_wdata, 2))
        else $error("host readback mismatch");

endmodule : entry_ram

/* rtl/multibuffered_serial_port.sv */
// Multibuffered serial port: group walker, shift engine, pin muxing.
// Assumes host ports are synchronous to i_clk_sys; pins are asynchronous.
//
// Contract
// R1 - Each word is 2 to 16 bits long, set per word.
// R2 - One 16-bit shift register sends and receives at the same time.
// R3 - Bit rate comes from the system clock by an 8-bit divider.
// R4 - Controller drives the serial clock; target follows the external one.
// R5 - Each word carries its own length, clock and delay settings.
// R6 - Pins not used by the link work as general-purpose inputs and outputs.
// R7 - The buffer holds 256 entries for queued words.
// R8 - Each entry has transmit, receive, control and status 16-bit fields.
// R9 - Transfer groups are runs of consecutive entries of any size.
// R10 - Controller drives clock and outgoing data and samples incoming data.
// R11 - Select leads first clock edge by delay plus 2, or 3 with hold.
// R12 - Select trails last edge by half period plus delay plus 1.
// R13 - A finished word stores its received data and sets its done status.
`timescale 1ns/1ps
module multibuffered_serial_port
    import mbsp_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    // Configuration
    input  wire logic              i_controller_mode,
    input  wire logic [7:0]        i_baud_div,
    // Transfer group
    input  wire logic              i_grp_go,
    input  wire logic [IDX_W-1:0]  i_grp_first,
    input  wire logic [IDX_W-1:0]  i_grp_last,
    output logic                   o_busy,
    output logic                   o_grp_done,
    // Host buffer access
    input  wire logic              i_host_we,
    input  wire logic [IDX_W-1:0]  i_host_entry,
    input  wire logic [1:0]        i_host_field,
    input  wire logic [WORD_W-1:0] i_host_wdata,
    output logic      [WORD_W-1:0] o_host_rdata,
    // Serial pins
    input  wire logic [PIN_N-1:0]  i_pin_in,
    output logic      [PIN_N-1:0]  o_pin_out,
    output logic      [PIN_N-1:0]  o_pin_oe_n,
    // General-purpose use of pins
    input  wire logic [PIN_N-1:0]  i_pin_func,
    input  wire logic [PIN_N-1:0]  i_gpio_dir,
    input  wire logic [PIN_N-1:0]  i_gpio_out,
    output logic      [PIN_N-1:0]  o_gpio_in
);

    // ----------------------------------------------------------------
    // Format decode
    // ----------------------------------------------------------------
    function automatic logic [4:0] len_of(input logic [15:0] c);
        logic [4:0] f;
        f = {1'b0, c[CTL_LEN_LSB +: CTL_LEN_W]} + 5'h01;
        len_of = (f < LEN_MIN) ? LEN_MIN : f;
    endfunction : len_of

    eng_state_e        state;
    eng_state_e        next_state;
    logic [IDX_W-1:0]  idx;
    logic [IDX_W-1:0]  last;
    logic [8:0]        cnt;
    logic [5:0]        edge_cnt;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] ctrl_q;
    logic [WORD_W-1:0] eng_tx;
    logic [WORD_W-1:0] eng_ctrl;
    logic              samp;
    logic              sclk_lvl;
    logic              sel_act;
    logic              mode_q;
    logic              sclk_prev;
    logic              tick;
    logic [PIN_N-1:0]  pin_meta;
    logic [PIN_N-1:0]  pin_sync;
    logic [PIN_N-1:0]  comm_val;
    logic [PIN_N-1:0]  comm_drv;

    wire [4:0] len      = len_of(ctrl_q); // see R1 see R5
    wire [4:0] load_len = len_of(eng_ctrl);
    wire       pol      = ctrl_q[CTL_POL];
    wire       pha      = ctrl_q[CTL_PHA];
    wire       hold     = ctrl_q[CTL_HOLD];
    wire [3:0] c2t      = ctrl_q[CTL_C2T_LSB +: CTL_DLY_W];
    wire [3:0] t2c      = ctrl_q[CTL_T2C_LSB +: CTL_DLY_W];
    wire [5:0] edges_total = {len, 1'b0};

    // ----------------------------------------------------------------
    // Timing decode
    // ----------------------------------------------------------------
    wire [8:0] setup_cycles = {5'h00, c2t} + SETUP_BASE + (hold ? HOLD_EXTRA : 9'h000); // see R11
    wire [8:0] desel_cycles = {1'b0, i_baud_div} + HALF_BASE + {5'h00, t2c} + DESEL_BASE; // see R12
    wire word_end   = (state == S_SHIFT) && (edge_cnt == edges_total);
    wire setup_done = (state == S_SETUP) && (cnt == setup_cycles - 9'h001); // see R11
    wire desel_end  = (state == S_DESEL) && (cnt == desel_cycles - DESEL_LAG); // see R12
    wire more_words = (idx != last);

    // ----------------------------------------------------------------
    // Clock edge events, own or followed
    // ----------------------------------------------------------------
    wire ctl_edge  = mode_q && (setup_done || (state == S_SHIFT && tick && !word_end)); // see R4
    wire sclk_now  = pin_sync[PIN_SERIAL_CLOCK] ^ pol;
    wire sclk_was  = sclk_prev ^ pol;
    wire tgt_sel   = !pin_sync[PIN_SELECT];
    wire tgt_ok    = !mode_q && (state == S_SHIFT) && tgt_sel; // see R4
    wire lead      = mode_q ? (ctl_edge && !sclk_lvl) : (tgt_ok && sclk_now && !sclk_was);
    wire trail     = mode_q ? (ctl_edge && sclk_lvl) : (tgt_ok && !sclk_now && sclk_was);
    wire sample_ev = pha ? trail : lead;
    wire shift_ev  = pha ? (lead && edge_cnt != 6'h00) : trail;
    wire in_bit    = mode_q ? pin_sync[PIN_CONTROLLER_IN] : pin_sync[PIN_CONTROLLER_OUT]; // see R10

    // Phase one takes its last bit after the final edge
    wire [15:0] rx_raw    = pha ? {shreg[14:0], samp} : shreg;
    wire [15:0] rx_word   = rx_raw & ~(16'hFFFF << len); // see R13
    wire [15:0] stat_word = STAT_RST | (16'h0001 << ST_DONE) | ({15'h0000, !mode_q} << ST_TGT); // see R13

    assign o_busy     = (state != S_IDLE);
    assign o_grp_done = (state == S_NEXT) && !more_words;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:  if (i_grp_go) next_state = S_LOAD;
            S_LOAD:  next_state = mode_q ? S_SETUP : S_SHIFT;
            S_SETUP: if (setup_done) next_state = S_SHIFT;
            S_SHIFT: if (word_end) next_state = mode_q ? S_DESEL : S_NEXT;
            S_DESEL: if (desel_end) next_state = S_NEXT;
            S_NEXT:  next_state = more_words ? S_LOAD : S_IDLE; // see R9
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state  <= S_IDLE;
            idx    <= 8'h00;
            last   <= 8'h00;
            mode_q <= 1'b0;
            ctrl_q <= 16'h0000;
        end else begin
            state <= next_state;
            if (state == S_IDLE) begin
                mode_q <= i_controller_mode;
            end
            if (state == S_IDLE && i_grp_go) begin
                idx  <= i_grp_first; // see R9
                last <= i_grp_last;
            end
            if (state == S_LOAD) begin
                ctrl_q <= eng_ctrl; // see R5
            end
            if (state == S_NEXT && more_words) begin
                idx <= idx + 8'h01; // see R9
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 9'h000;
        end else if (state != next_state) begin
            cnt <= 9'h000;
        end else begin
            cnt <= cnt + 9'h001;
        end
    end

    // ----------------------------------------------------------------
    // Shift engine
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            shreg    <= 16'h0000;
            samp     <= 1'b0;
            edge_cnt <= 6'h00;
            sclk_lvl <= 1'b0;
        end else if (state == S_LOAD) begin
            shreg    <= eng_tx << (LEN_MAX - load_len); // see R1
            edge_cnt <= 6'h00;
            sclk_lvl <= 1'b0;
        end else begin
            if (lead || trail) edge_cnt <= edge_cnt + 6'h01;
            if (ctl_edge) sclk_lvl <= !sclk_lvl; // see R4
            if (sample_ev) samp <= in_bit; // see R2
            if (shift_ev) shreg <= {shreg[14:0], samp}; // see R2
        end
    end

    // Select stays asserted across words that ask for hold
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_act <= 1'b0;
        end else if (state == S_LOAD && mode_q) begin
            sel_act <= 1'b1; // see R11
        end else if (desel_end && !(hold && more_words)) begin
            sel_act <= 1'b0; // see R12
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta  <= 4'h0;
            pin_sync  <= 4'h0;
            sclk_prev <= 1'b0;
        end else begin
            pin_meta  <= i_pin_in;
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync[PIN_SERIAL_CLOCK];
        end
    end

    // ----------------------------------------------------------------
    // Pin muxing
    // ----------------------------------------------------------------
    assign comm_val[PIN_SERIAL_CLOCK]   = sclk_lvl ^ pol;
    assign comm_val[PIN_CONTROLLER_OUT] = shreg[15];
    assign comm_val[PIN_CONTROLLER_IN]  = shreg[15];
    assign comm_val[PIN_SELECT]         = !sel_act;
    assign comm_drv[PIN_SERIAL_CLOCK]   = mode_q; // see R10
    assign comm_drv[PIN_CONTROLLER_OUT] = mode_q; // see R10
    assign comm_drv[PIN_CONTROLLER_IN]  = !mode_q && tgt_sel;
    assign comm_drv[PIN_SELECT]         = mode_q;

    generate
        for (genvar k = 0; k < PIN_N; k++) begin : g_pin
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_pin_out[k]  <= 1'b0;
                    o_pin_oe_n[k] <= 1'b1;
                    o_gpio_in[k]  <= 1'b0;
                end else begin
                    o_pin_out[k]  <= i_pin_func[k] ? comm_val[k] : i_gpio_out[k]; // see R6
                    o_pin_oe_n[k] <= i_pin_func[k] ? !comm_drv[k] : !i_gpio_dir[k]; // see R6
                    o_gpio_in[k]  <= pin_sync[k];
                end
            end

            gpio_mux_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // see R6
                !i_pin_func[k] |=> o_pin_oe_n[k] == !$past(i_gpio_dir[k])
                    && o_pin_out[k] == $past(i_gpio_out[k]))
                else $error("gpio pin not passed through");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    baud_gen u_baud (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_run     (mode_q && state == S_SHIFT),
        .i_div     (i_baud_div),
        .o_tick    (tick)
    );

    entry_ram u_ram (
        .i_clk_sys    (i_clk_sys),
        .i_nrst       (i_nrst),
        .i_host_we    (i_host_we),
        .i_host_entry (i_host_entry),
        .i_host_field (i_host_field),
        .i_host_wdata (i_host_wdata),
        .o_host_rdata (o_host_rdata),
        .i_eng_entry  (idx),
        .i_eng_we     (state == S_NEXT),
        .i_eng_rx     (rx_word),
        .i_eng_stat   (stat_word),
        .o_eng_tx     (eng_tx),
        .o_eng_ctrl   (eng_ctrl)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [8:0] gap;
    logic [8:0] sel_age;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            gap     <= 9'h000;
            sel_age <= 9'h000;
        end else begin
            gap     <= ctl_edge ? 9'h000 : gap + 9'h001;
            sel_age <= (state == S_LOAD) ? 9'h000 : sel_age + 9'h001;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence last_edge_s;
        mode_q && ctl_edge && (edge_cnt == edges_total - 6'h01);
    endsequence
    sequence to_desel_s;
        ##1 word_end ##1 (state == S_DESEL);
    endsequence

    len_range_a: assert property ((state == S_SHIFT) |-> len >= LEN_MIN && len <= LEN_MAX) // see R1
        else $error("word length out of range");
    word_edges_a: assert property (last_edge_s |-> to_desel_s) // see R2
        else $error("word did not end after its last edge");
    half_period_a: assert property ((state == S_SHIFT && ctl_edge) |-> gap == {1'b0, i_baud_div}) // see R3
        else $error("serial clock half period wrong");
    target_follow_a: assert property (!mode_q |-> (!tick && !ctl_edge) // see R4
        ##1 (o_pin_oe_n[PIN_SERIAL_CLOCK] || !$past(i_pin_func[PIN_SERIAL_CLOCK])))
        else $error("target made its own clock");
    ctrl_pins_a: assert property ((mode_q && state == S_SHIFT && i_pin_func == 4'hF) // see R10
        |=> !o_pin_oe_n[PIN_SERIAL_CLOCK] && !o_pin_oe_n[PIN_CONTROLLER_OUT]
            && o_pin_oe_n[PIN_CONTROLLER_IN])
        else $error("controller pin directions wrong");
    setup_delay_a: assert property (setup_done |-> sel_act && sel_age == setup_cycles - 9'h001) // see R11
        else $error("select to clock delay wrong");
    desel_delay_a: assert property ($fell(sel_act) |-> gap == desel_cycles) // see R12
        else $error("clock to deselect delay wrong");
    fmt_latch_a: assert property ((state == S_LOAD) |=> ctrl_q == $past(eng_ctrl)) // see R5
        else $error("word format not taken");
    grp_walk_a: assert property ((state == S_NEXT && more_words) // see R9
        |=> state == S_LOAD && idx == $past(idx) + 8'h01)
        else $error("group walk skipped an entry");
    store_done_a: assert property ((state == S_NEXT) |-> stat_word[ST_DONE] // see R13
        && stat_word[ST_TGT] == !mode_q && ($past(state) == S_SHIFT || $past(state) == S_DESEL))
        else $error("done status not stored once");

endmodule : multibuffered_serial_port

/* tb/spi_peripheral_model.sv */
// Serial peripheral model: mode 0 target that answers i_resp MSB first.
// Assumes select idles high and the serial clock idles low.
`timescale 1ns/1ps
module spi_peripheral_model (
    // Link
    input  wire logic        i_sclk,
    input  wire logic        i_mosi,
    input  wire logic        i_sel_n,
    // Word to answer and word seen
    input  wire logic [15:0] i_resp,
    output logic             o_miso,
    output logic      [15:0] o_got
);
    int idx = 15;
    initial o_miso = 1'b0;
    initial o_got = 16'h0000;
    // Follows the controller's select and clock
    always @(negedge i_sel_n) begin
        idx = 15;
        o_got = 16'h0000;
        o_miso = i_resp[15];
    end
    // Samples on the leading edge, shifts out on the trailing one
    always @(posedge i_sclk) if (!i_sel_n) o_got = {o_got[14:0], i_mosi};
    always @(negedge i_sclk) if (!i_sel_n && idx > 0) begin
        idx = idx - 1;
        o_miso = i_resp[idx];
    end
    // A released line shows the inverse of its last value
    always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule : spi_peripheral_model

/* tb/testbench.sv */
// Self-checking bench for the multibuffered serial port in controller mode, then a target-mode stall and GPIO pass-through.
// Assumes the peripheral model is compiled before this file.
`timescale 1ns/1ps
module testbench
    import mbsp_pkg::*;
;
    logic        i_clk_sys, i_nrst, i_grp_go, i_host_we, o_busy, o_grp_done, miso, arm, mode;
    logic [7:0]  i_baud_div, i_grp_first, i_grp_last, i_host_entry, f0;
    logic [1:0]  i_host_field;
    logic [15:0] i_host_wdata, o_host_rdata, resp, got, rdv, c, e_m[4];
    logic [3:0]  o_pin_out, o_pin_oe_n, i_pin_func, i_gpio_dir, i_gpio_out, o_gpio_in, pv;
    wire  [3:0]  pin = (o_pin_oe_n & {1'b1, miso, 2'b00}) | (~o_pin_oe_n & o_pin_out);
    int          fail_count = 0, checked = 0, wi = 0, sc = 0, hc = 0, tg = 0, n, nw, e_s[4], e_h[4], e_l[4];

    multibuffered_serial_port u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_controller_mode(mode),
        .i_baud_div(i_baud_div), .i_grp_go(i_grp_go), .i_grp_first(i_grp_first), .i_grp_last(i_grp_last),
        .o_busy(o_busy), .o_grp_done(o_grp_done), .i_host_we(i_host_we), .i_host_entry(i_host_entry),
        .i_host_field(i_host_field), .i_host_wdata(i_host_wdata), .o_host_rdata(o_host_rdata),
        .i_pin_in(pin), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .i_pin_func(i_pin_func),
        .i_gpio_dir(i_gpio_dir), .i_gpio_out(i_gpio_out), .o_gpio_in(o_gpio_in));
    spi_peripheral_model u_peer (.i_sclk(pin[0]), .i_mosi(pin[1]), .i_sel_n(pin[3]), .i_resp(resp),
        .o_miso(miso), .o_got(got));

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    task automatic step; @(posedge i_clk_sys); #1; endtask : step
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] e, input logic [1:0] f, input logic [15:0] d);
        {i_host_we, i_host_entry, i_host_field, i_host_wdata} = {1'b1, e, f, d};
        step;
    endtask : wr
    task automatic host_rd(input logic [7:0] e, input logic [1:0] f);
        {i_host_we, i_host_entry, i_host_field} = {1'b0, e, f};
        step;
        rdv = o_host_rdata;
    endtask : host_rd
    function automatic int len_of(input logic [15:0] w);
        return (w[3:0] == 4'h0) ? 2 : int'(w[3:0]) + 1;
    endfunction : len_of

    // ----------------------------------------------------------------
    // Link monitor: select lead, bit spacing, select trail, word content
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (arm && wi < 4) begin
            sc++;
            hc++;
            if (pv[3] && !pin[3]) begin
                sc = 0;
                tg = 0;
                check({12'h000, o_pin_oe_n}, 16'h0004);
            end
            if (pin[0] !== pv[0] && !pin[3]) begin
                if (tg == 0) check(16'(sc), 16'(e_s[wi]));
                else check(16'(hc), {8'h00, i_baud_div} + 16'h0001);
                tg++;
                hc = 0;
            end
            if (!pv[3] && pin[3]) begin
                check(16'(hc), 16'(e_h[wi]));
                check(16'(tg), 16'(2 * e_l[wi]));
                check(got, e_m[wi]);
                wi++;
            end
        end
        pv = pin;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {i_nrst, i_grp_go, i_host_we, arm, i_baud_div, i_grp_first, i_grp_last} = '0;
        {i_host_entry, i_host_field, i_host_wdata, resp} = '0;
        {i_pin_func, i_gpio_dir, i_gpio_out} = {4'hF, 4'h0, 4'h0};
        mode = 1'b1;
        void'($urandom(32'h3A97));
        repeat (4) step;
        check({12'h000, o_pin_oe_n}, 16'h000F);
        check({15'h0000, o_busy}, 16'h0000);
        i_nrst = 1'b1;
        repeat (2) step;
        arm = 1'b1;
        for (int g = 0; g < 4; g++) begin
            nw = (g == 0) ? 3 : $urandom_range(3, 1);
            f0 = (g == 0) ? 8'hFD : 8'($urandom_range(250, 0));
            // Pin round trip through output register and synchroniser takes three cycles
            i_baud_div = 8'($urandom_range(6, 3));
            resp = 16'($urandom);
            for (int k = 0; k < nw; k++) begin
                c = (16'($urandom) & ((k < nw - 1) ? 16'hFF0F : 16'hFF4F)) | 16'h0200;
                e_m[k] = 16'($urandom);
                e_l[k] = len_of(c);
                e_s[k] = int'(c[11:8]) + 2 + int'(c[6]);
                e_h[k] = int'(i_baud_div) + 2 + int'(c[15:12]);
                wr(f0 + 8'(k), FLD_TX, e_m[k]);
                wr(f0 + 8'(k), FLD_CTRL, c);
                wr(f0 + 8'(k), FLD_STAT, 16'h0000);
                host_rd(f0 + 8'(k), FLD_CTRL);
                check(rdv, c);
                e_m[k] = e_m[k] & (16'hFFFF >> (16 - e_l[k]));
            end
            wi = 0;
            {i_grp_go, i_grp_first, i_grp_last} = {1'b1, f0, f0 + 8'(nw - 1)};
            step;
            check({15'h0000, o_busy}, 16'h0001);
            {i_grp_first, i_grp_last} = {8'h00, 8'h00};
            step;
            i_grp_go = 1'b0;
            for (n = 0; n < 3000 && o_grp_done !== 1'b1; n++) step;
            if (n == 3000) begin
                fail_count++;
                final_report;
            end
            step;
            check({15'h0000, o_busy}, 16'h0000);
            step;
            check(16'(wi), 16'(nw));
            for (int k = 0; k < nw; k++) begin
                host_rd(f0 + 8'(k), FLD_RX);
                check(rdv, resp >> (16 - e_l[k]));
                host_rd(f0 + 8'(k), FLD_STAT);
                check(rdv, 16'h0001);
            end
        end
        arm = 1'b0;
        // Target mode with no external clock: waits, drives nothing, leaves only by reset
        mode = 1'b0;
        {i_grp_go, i_grp_first, i_grp_last} = {1'b1, f0, f0};
        step;
        i_grp_go = 1'b0;
        repeat (4) step;
        check({15'h0000, o_busy}, 16'h0001);
        check({12'h000, o_pin_oe_n}, 16'h000F);
        i_nrst = 1'b0;
        step;
        check({15'h0000, o_busy}, 16'h0000);
        {i_nrst, mode} = 2'b11;
        repeat (2) step;
        {i_pin_func, i_gpio_dir, i_gpio_out} = {4'h0, 4'hB, 4'($urandom)};
        repeat (6) step;
        check({12'h000, o_pin_oe_n}, 16'h0004);
        check({12'h000, o_pin_out & 4'hB}, {12'h000, i_gpio_out & 4'hB});
        check({12'h000, o_gpio_in}, {12'h000, i_gpio_out[3], miso, i_gpio_out[1:0]});
        final_report;
    end
endmodule : testbench
